// [apc_apb_decode.sv]
// Module: APB address decode and handshake for the pad configuration bank
`timescale 1ns/1ps
`default_nettype none
module apc_apb_decode #(
  parameter int unsigned ADDR_W = apc_pkg::ADDR_W
) (
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  output logic      [apc_pkg::IDX_W-1:0] reg_idx,
  output logic                          addr_hit,
  output logic                          wr_fire,
  output logic                          rd_setup,
  output logic                          pready,
  output logic                          pslverr
);
  logic [ADDR_W-1:0] rel_off;

  // Below-base addresses wrap high and so miss
  assign rel_off  = paddr - ADDR_W'(apc_pkg::BANK_BASE_OFF);
  assign addr_hit = (rel_off[1:0] == 2'h0) &&
                    (rel_off[ADDR_W-1:2] < (ADDR_W-2)'(apc_pkg::NUM_REGS));
  assign reg_idx  = rel_off[apc_pkg::IDX_W+1:2];

  // Zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_hit;
  assign wr_fire  = psel && penable && pwrite && addr_hit;
  assign rd_setup = psel && !penable && !pwrite;
endmodule : apc_apb_decode
`default_nettype wire

// [apc_bank.sv]
// Module: alternate pad configuration register bank, pads 8 to 35, APB slave
//
// Functional notes
// - A slew-select bit at 1 turns on slew-rate limiting for its pad, at 0 the pad runs without it.
// - Each pad's high drive bit joins the low drive field from elsewhere to form its drive strength.
// - Each register serves four pads, slew at bits 28/20/12/4 and drive at 24/16/8/0, top pad highest.
// - Registers sit at consecutive words, pads 8-11 at 0xE8 rising by four up to pads 32-35 at 0x100.
`timescale 1ns/1ps
`default_nettype none
module apc_bank #(
  parameter int unsigned ADDR_W = apc_pkg::ADDR_W,
  parameter int unsigned LOW_W  = apc_pkg::DRIVE_LOW_W
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [ADDR_W-1:0]                   paddr,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [apc_pkg::NUM_PADS*LOW_W-1:0]  pad_drive_low_field,
  output logic      [apc_pkg::NUM_PADS-1:0]        slew_limit_on,
  output logic      [apc_pkg::NUM_PADS*(LOW_W+1)-1:0] pad_drive_strength
);
  localparam int unsigned NREG  = apc_pkg::NUM_REGS;
  localparam int unsigned NPADS = apc_pkg::NUM_PADS;

  // Refuse shapes the decode and field map cannot serve
  generate
    if (LOW_W < 1 || ADDR_W < 9 || ADDR_W > 32) begin : g_bad_param
      $error("apc_bank: unsupported LOW_W or ADDR_W");
    end
    if (apc_pkg::NUM_REGS > (1 << apc_pkg::IDX_W)) begin : g_bad_layout
      $error("apc_bank: register count exceeds index width");
    end
  endgenerate

  logic [apc_pkg::IDX_W-1:0] reg_idx;
  logic                      addr_hit;
  logic                      wr_fire;
  logic                      rd_setup;

  logic [31:0]          cfg_r   [NREG];
  logic [31:0]          cfg_nxt [NREG];
  logic [31:0]          prdata_r;
  logic [31:0]          prdata_nxt;
  logic [NPADS-1:0]     slew_sel_w;
  logic [NPADS-1:0]     drive_hi_w;

  apc_apb_decode #(
    .ADDR_W (ADDR_W)
  ) i_apc_apb_decode (
    .paddr    (paddr),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .reg_idx  (reg_idx),
    .addr_hit (addr_hit),
    .wr_fire  (wr_fire),
    .rd_setup (rd_setup),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  // Register storage: byte-lane writes, only defined bits kept
  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      cfg_nxt[r] = cfg_r[r];
      if (wr_fire && (reg_idx == apc_pkg::IDX_W'(r))) begin
        for (int b = 0; b < 4; b++) begin
          if (pstrb[b]) begin
            cfg_nxt[r][b*8 +: 8] = pwdata[b*8 +: 8] & apc_pkg::WRITABLE_MASK[b*8 +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < NREG; r++) begin
        cfg_r[r] <= apc_pkg::CFG_RESET_VAL;
      end
    end else begin
      for (int r = 0; r < NREG; r++) begin
        cfg_r[r] <= cfg_nxt[r];
      end
    end
  end

  // Read data captured in setup so it leaves a flip-flop in access
  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_setup) begin
      prdata_nxt = addr_hit ? cfg_r[reg_idx] : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // Field map: pad slot s of register r is pad 8 + 4r + s
  genvar p;
  generate
    for (p = 0; p < NPADS; p++) begin : g_map
      localparam int unsigned R = p / apc_pkg::PADS_PER_REG;
      localparam int unsigned S = p % apc_pkg::PADS_PER_REG;
      assign slew_sel_w[p] = cfg_r[R][S*apc_pkg::SLOT_STRIDE + apc_pkg::SLEW_BIT_POS];
      assign drive_hi_w[p] = cfg_r[R][S*apc_pkg::SLOT_STRIDE + apc_pkg::DRIVE_BIT_POS];
    end
  endgenerate

  apc_pad_drive #(
    .NPADS (NPADS),
    .LOW_W (LOW_W)
  ) i_apc_pad_drive (
    .pclk               (pclk),
    .presetn            (presetn),
    .slew_sel           (slew_sel_w),
    .drive_hi           (drive_hi_w),
    .drive_low          (pad_drive_low_field),
    .slew_limit_on      (slew_limit_on),
    .pad_drive_strength (pad_drive_strength)
  );

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [NREG*32-1:0] cfg_flat;
  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      cfg_flat[r*32 +: 32] = cfg_r[r];
    end
  end

  logic full_wr;
  assign full_wr = wr_fire && (pstrb == 4'hF);

  logic rd_access;
  assign rd_access = psel && penable && !pwrite;

  a_read_matches_reg: assert property (
    rd_access && addr_hit |-> prdata == cfg_r[reg_idx])
    else $error("read data differs from addressed register");

  a_reserved_read_zero: assert property (
    rd_access |-> (prdata & ~apc_pkg::WRITABLE_MASK) == 32'h0000_0000)
    else $error("reserved bit read as one");

  a_unmapped_read_zero: assert property (
    rd_access && !addr_hit |-> prdata == 32'h0000_0000 && pslverr)
    else $error("unmapped read not zero with error");

  a_write_lands_word: assert property (
    full_wr |=> cfg_r[$past(reg_idx)] == ($past(pwdata) & apc_pkg::WRITABLE_MASK))
    else $error("full write did not land masked");

  a_unmapped_no_write: assert property (
    psel && penable && pwrite && !addr_hit |=> $stable(cfg_flat))
    else $error("unmapped write altered the bank");

  a_setup_then_ready: assert property (
    psel && !penable |=> penable |-> pready && (pslverr == !addr_hit))
    else $error("access phase not answered at once");

  a_slew_follows_write: assert property (
    full_wr && reg_idx == 3'h1 && pwdata[apc_pkg::SLEW_BIT_POS + 24] |-> ##2 slew_limit_on[7])
    else $error("top pad of second group missed slew enable");

  a_slew_off_write: assert property (
    full_wr && reg_idx == 3'h0 && !pwdata[apc_pkg::SLEW_BIT_POS] |-> ##2 !slew_limit_on[0])
    else $error("lowest pad slew stayed on after clear");

  a_drive_combine: assert property (
    1'b1 |=> pad_drive_strength[LOW_W:0] ==
             {$past(cfg_r[0][apc_pkg::DRIVE_BIT_POS]), $past(pad_drive_low_field[LOW_W-1:0])})
    else $error("pad drive strength not high bit over low field");

  a_drive_slot_map: assert property (
    full_wr && reg_idx == 3'h6 |-> ##2
      pad_drive_strength[(NPADS-1)*(LOW_W+1) + LOW_W] == $past(pwdata[24], 2))
    else $error("top pad drive bit not taken from bit 24");

  a_error_only_access: assert property (
    !(psel && penable) |-> !pslverr)
    else $error("error flag outside an access phase");

  a_error_on_miss: assert property (
    psel && penable && !addr_hit |-> pslverr)
    else $error("unmapped access not flagged");

  a_hit_no_error: assert property (
    psel && penable && addr_hit |-> !pslverr)
    else $error("mapped access flagged an error");

  a_ready_in_access: assert property (
    psel && penable |-> pready)
    else $error("access phase held in wait");

  a_hit_aligned: assert property (
    addr_hit |-> paddr[1:0] == 2'h0)
    else $error("misaligned address decoded as a hit");

  a_hit_in_range: assert property (
    addr_hit |-> paddr >= ADDR_W'(apc_pkg::PAD_GROUP8_11_EXTRA_CFG_OFF) &&
                 paddr <= ADDR_W'(apc_pkg::PAD_GROUP32_35_EXTRA_CFG_OFF))
    else $error("address outside the bank decoded as a hit");

  a_idle_no_write: assert property (
    !psel |=> $stable(cfg_flat))
    else $error("bank changed while the bus was idle");

  a_setup_no_write: assert property (
    psel && !penable |=> $stable(cfg_flat))
    else $error("bank changed in a setup cycle");

  a_read_no_write: assert property (
    rd_access |=> $stable(cfg_flat))
    else $error("bank changed during a read");

  a_strobe_none_hold: assert property (
    wr_fire && pstrb == 4'h0 |=> $stable(cfg_flat))
    else $error("write with no strobes altered the bank");

  a_prdata_loads: assert property (
    rd_setup && addr_hit |=> prdata == $past(cfg_r[reg_idx]))
    else $error("read setup did not load the addressed register");

  a_unmapped_setup_zero: assert property (
    rd_setup && !addr_hit |=> prdata == 32'h0000_0000)
    else $error("unmapped read setup loaded nonzero data");

  a_read_data_holds: assert property (
    !rd_setup |=> $stable(prdata))
    else $error("read data moved outside a read setup");

  a_drive_high_write: assert property (
    full_wr && reg_idx == 3'h0 && pwdata[apc_pkg::DRIVE_BIT_POS] |-> ##2 pad_drive_strength[LOW_W])
    else $error("lowest pad missed its drive high bit");

  a_slew_low_group: assert property (
    full_wr && reg_idx == 3'h6 |-> ##2 slew_limit_on[24] == $past(pwdata[apc_pkg::SLEW_BIT_POS], 2))
    else $error("lowest pad of last group not taken from bit 4");

  // Per register: a word only moves when written, and only in its strobed lanes
  generate
    for (genvar gr = 0; gr < NREG; gr++) begin : g_reg_chk
      a_word_holds: assert property (
        !(wr_fire && reg_idx == apc_pkg::IDX_W'(gr)) |=> $stable(cfg_r[gr]))
        else $error("register changed without a write to it");

      a_reserved_clear: assert property (
        1'b1 |-> (cfg_r[gr] & ~apc_pkg::WRITABLE_MASK) == 32'h0000_0000)
        else $error("reserved register bit held a one");

      for (genvar gb = 0; gb < 4; gb++) begin : g_lane
        a_lane_lands: assert property (
          wr_fire && reg_idx == apc_pkg::IDX_W'(gr) && pstrb[gb] |=>
            cfg_r[gr][gb*8 +: 8] == ($past(pwdata[gb*8 +: 8]) & apc_pkg::WRITABLE_MASK[gb*8 +: 8]))
          else $error("strobed lane did not land masked");

        a_lane_kept: assert property (
          wr_fire && reg_idx == apc_pkg::IDX_W'(gr) && !pstrb[gb] |=> $stable(cfg_r[gr][gb*8 +: 8]))
          else $error("unstrobed lane changed");
      end
    end
  endgenerate

  // Per pad: outputs trail their register bits and low drive field by one edge, never more
  generate
    for (p = 0; p < NPADS; p++) begin : g_pad_chk
      localparam int unsigned CR = p / apc_pkg::PADS_PER_REG;
      localparam int unsigned CS = p % apc_pkg::PADS_PER_REG;

      a_pad_slew: assert property (
        1'b1 |=> slew_limit_on[p] == $past(cfg_r[CR][CS*apc_pkg::SLOT_STRIDE + apc_pkg::SLEW_BIT_POS]))
        else $error("pad slew limit not its slew select bit");

      a_pad_drive_high: assert property (
        1'b1 |=> pad_drive_strength[p*(LOW_W+1) + LOW_W] ==
                 $past(cfg_r[CR][CS*apc_pkg::SLOT_STRIDE + apc_pkg::DRIVE_BIT_POS]))
        else $error("pad drive high bit not its register bit");

      a_pad_drive_low: assert property (
        1'b1 |=> pad_drive_strength[p*(LOW_W+1) +: LOW_W] == $past(pad_drive_low_field[p*LOW_W +: LOW_W]))
        else $error("pad drive low bits not the low field");
    end
  endgenerate

  c_read_hit:   cover property (rd_access && addr_hit);
  c_write_hit:  cover property (full_wr);
  c_unmapped:   cover property (psel && penable && !addr_hit);
  c_slew_on:    cover property ($rose(slew_limit_on[NPADS-1]));
  c_lane_part:  cover property (wr_fire && pstrb != 4'hF);
endmodule : apc_bank
`default_nettype wire

// [apc_bank_tb.sv]
// Testbench: APB register map and pad output checks for the pad configuration bank
`timescale 1ns/1ps
`default_nettype none
module apc_bank_tb;
  typedef struct packed {logic [11:0] addr; logic [31:0] wdata; logic [31:0] rdata;} apc_row_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [3:0]  pstrb;
  logic [27:0] low;
  logic [27:0] slew;
  logic [27:0] exp_slew;
  logic [55:0] drv;
  logic [55:0] exp_drv;
  int          miscompares;
  int          compares;
  int          cycles;
  // Reserved bits set in some rows so that a leaky mask shows up
  apc_row_t    rows [0:6] = '{'{12'h0E8, 32'h0000_0011, 32'h0000_0011}, '{12'h0EC, 32'h1100_0000, 32'h1100_0000},
                              '{12'h0F0, 32'h0033_0F00, 32'h0011_0100}, '{12'h0F4, 32'hFFFF_FFFF, 32'h1111_1111},
                              '{12'h0F8, 32'h0101_0101, 32'h0101_0101}, '{12'h0FC, 32'h1010_1010, 32'h1010_1010},
                              '{12'h100, 32'hFEEE_9001, 32'h1000_1001}};
  // Misaligned entry could alias onto the first register
  logic [11:0] bad [0:2] = '{12'h0E4, 12'h104, 12'h0EA};

  apc_bank i_apc_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_drive_low_field(low), .slew_limit_on(slew), .pad_drive_strength(drv));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask : chk

  // Master waits on pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic read_all(input logic clr);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0, 4'h0);
      chk("readback", clr ? 32'h0 : rows[i].rdata, rd);
      chk("pslverr", 1'b0, err);
    end
  endtask : read_all

  task automatic chk_pads();
    for (int r = 0; r < 7; r++) begin
      for (int s = 0; s < 4; s++) begin
        exp_slew[4*r+s] = rows[r].rdata[8*s+4];
        exp_drv[8*r+2*s+1] = rows[r].rdata[8*s];
        exp_drv[8*r+2*s] = low[4*r+s];
      end
    end
    chk("slew_limit_on", exp_slew, slew);
    chk("pad_drive_strength", exp_drv, drv);
  endtask : chk_pads

  task automatic finish_test();
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    low = 28'hA5C_3E69;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    read_all(1'b1);
    $display("test reset values done");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdata, 4'hF);
    end
    read_all(1'b0);
    chk_pads();
    $display("test register map done");
    // Only byte lane 0 may clear
    apb(1'b1, 12'h0F4, 32'h0, 4'h1);
    apb(1'b1, 12'h0E8, 32'h0000_0001, 4'hF);
    low <= 28'h5A3_C196;
    rows[3].rdata = 32'h1111_1100;
    rows[0].rdata = 32'h0000_0001;
    read_all(1'b0);
    chk_pads();
    $display("test byte strobe done");
    foreach (bad[i]) begin
      apb(1'b1, bad[i], 32'hFFFF_FFFF, 4'hF);
      chk("write error", 1'b1, err);
      apb(1'b0, bad[i], 32'h0, 4'h0);
      chk("unmapped read", 32'h0, rd);
      chk("read error", 1'b1, err);
    end
    read_all(1'b0);
    $display("test unmapped done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("slew in reset", 28'h0, slew);
    chk("drive in reset", 56'h0, drv);
    presetn <= 1'b1;
    read_all(1'b1);
    $display("test second reset done");
    finish_test();
  end
endmodule : apc_bank_tb
`default_nettype wire

// [apc_pad_drive.sv]
// Module: per-pad slew and drive strength output stage
`timescale 1ns/1ps
`default_nettype none
module apc_pad_drive #(
  parameter int unsigned NPADS = apc_pkg::NUM_PADS,
  parameter int unsigned LOW_W = apc_pkg::DRIVE_LOW_W
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [NPADS-1:0]         slew_sel,
  input  wire logic [NPADS-1:0]         drive_hi,
  input  wire logic [NPADS*LOW_W-1:0]   drive_low,
  output logic      [NPADS-1:0]         slew_limit_on,
  output logic      [NPADS*(LOW_W+1)-1:0] pad_drive_strength
);
  genvar p;
  generate
    for (p = 0; p < NPADS; p++) begin : g_pad
      logic             slew_r;
      logic             slew_nxt;
      logic [LOW_W:0]   drv_r;
      logic [LOW_W:0]   drv_nxt;

      always_comb begin
        slew_nxt = slew_sel[p];
        drv_nxt  = {drive_hi[p], drive_low[p*LOW_W +: LOW_W]};
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          slew_r <= 1'b0;
          drv_r  <= '0;
        end else begin
          slew_r <= slew_nxt;
          drv_r  <= drv_nxt;
        end
      end

      assign slew_limit_on[p] = slew_r;
      assign pad_drive_strength[p*(LOW_W+1) +: LOW_W+1] = drv_r;
    end
  endgenerate
endmodule : apc_pad_drive
`default_nettype wire

// [apc_pkg.sv]
// Package: register map and field layout of the alternate pad configuration bank
`default_nettype none
package apc_pkg;
  localparam int unsigned NUM_REGS      = 7;
  localparam int unsigned PADS_PER_REG  = 4;
  localparam int unsigned FIRST_PAD     = 8;
  localparam int unsigned NUM_PADS      = NUM_REGS * PADS_PER_REG;
  localparam int unsigned IDX_W         = 3;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 32;

  // Word offsets, one register per group of four pads
  localparam logic [11:0] PAD_GROUP8_11_EXTRA_CFG_OFF  = 12'h0E8;
  localparam logic [11:0] PAD_GROUP12_15_EXTRA_CFG_OFF = 12'h0EC;
  localparam logic [11:0] PAD_GROUP16_19_EXTRA_CFG_OFF = 12'h0F0;
  localparam logic [11:0] PAD_GROUP20_23_EXTRA_CFG_OFF = 12'h0F4;
  localparam logic [11:0] PAD_GROUP24_27_EXTRA_CFG_OFF = 12'h0F8;
  localparam logic [11:0] PAD_GROUP28_31_EXTRA_CFG_OFF = 12'h0FC;
  localparam logic [11:0] PAD_GROUP32_35_EXTRA_CFG_OFF = 12'h100;
  localparam logic [11:0] BANK_BASE_OFF = PAD_GROUP8_11_EXTRA_CFG_OFF;

  // Field layout inside one register, per pad slot
  localparam int unsigned SLOT_STRIDE   = 8;
  localparam int unsigned SLEW_BIT_POS  = 4;
  localparam int unsigned DRIVE_BIT_POS = 0;
  localparam logic [31:0] WRITABLE_MASK = 32'h1111_1111;
  localparam logic [31:0] CFG_RESET_VAL = 32'h0000_0000;

  // Default width of the low-order drive field held elsewhere
  localparam int unsigned DRIVE_LOW_W   = 1;
endpackage : apc_pkg
`default_nettype wire
